// ==== logic/asc_pkg.sv ====
`default_nettype none
package asc_pkg;
	localparam int NCH = 6;
	localparam int NTMR = 3;
	localparam int NPAIR = 3;
	localparam int NTRIG = 8;
	localparam int CW = 16;
	localparam int MW = 4;
	// Register word indices on the configuration port.
	localparam logic [4:0] ADDR_PAIR_SEL = 5'h00;
	localparam logic [4:0] ADDR_LEGACY = 5'h01;
	localparam logic [4:0] ADDR_CTL_BASE = 5'h02;
	localparam logic [4:0] ADDR_MODE_BASE = 5'h08;
	localparam logic [4:0] ADDR_CMP_BASE = 5'h0E;
	localparam logic [4:0] ADDR_SPAN = 5'h06;
	// Field positions.
	localparam int SEL_EVEN_LSB = 0;
	localparam int SEL_ODD_LSB = 4;
	localparam int PAIR_SEL_W = 8;
	localparam int LEG_MODE_LSB = 8;
	localparam int BUFFER_TRANSFER_MODE_LSB = 0;
	localparam int TRIG_LSB = 2;
	localparam int LINK_BIT = 5;
	localparam int MCV_LSB = 8;
	localparam int MODE_LSB = 8;
	localparam int MODE_AMOD = 0;
	localparam int MODE_OCUS = 1;
	localparam int MODE_DE = 4;
	localparam int MODE_PE = 5;
	localparam int MODE_UE = 6;
	localparam int MODE_ZE = 7;
	// Write masks keep reserved bits at zero.
	localparam logic [7:0] CTL_WMASK = 8'h1F;
	localparam logic [7:0] CTL_LINK_MASK = 8'h20;
	localparam logic [7:0] MODE_WMASK = 8'hF3;
	localparam logic [5:0] LEG_WMASK = 6'h3F;
	// Codes and reset values.
	localparam logic [3:0] TSEL_MAX = 4'h2;
	localparam logic [1:0] LEG_ON = 2'h1;
	localparam logic [MW-1:0] MASK_ZERO = 4'h0;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [CW-1:0] CMP_RST = 16'h0000;
	localparam logic [CW-1:0] CNT_ONE = 16'h0001;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
	typedef enum logic [1:0] {
		ASC_BUF_NOW = 2'b00,
		ASC_BUF_ZERO = 2'b01,
		ASC_BUF_PEAK = 2'b10,
		ASC_BUF_BOTH = 2'b11
	} asc_buffer_transfer_mode_t;
endpackage
`default_nettype wire

// ==== logic/asc_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface asc_link_if;
	import asc_pkg::*;
	logic [NTMR-1:0][CW-1:0] frt_count;
	logic [NTMR-1:0] frt_tick;
	logic [NTMR-1:0] frt_zero;
	logic [NTMR-1:0] frt_peak;
	logic [NTMR-1:0] frt_up;
	logic [NTMR-1:0] frt_stop;
	logic [NTMR-1:0][MW-1:0] zero_side_mask_count;
	logic [NTMR-1:0][MW-1:0] peak_side_mask_count;
	logic [NCH-1:0][1:0] output_compare_value_match;
	logic [NTRIG-1:0] adc_trig;
	modport dev (
		input frt_count, frt_tick, frt_zero, frt_peak, frt_up, frt_stop,
		input zero_side_mask_count, peak_side_mask_count, output_compare_value_match,
		output adc_trig
	);
	modport tmr (
		output frt_count, frt_tick, frt_zero, frt_peak, frt_up, frt_stop,
		output zero_side_mask_count, peak_side_mask_count, output_compare_value_match,
		input adc_trig
	);
endinterface
`default_nettype wire

// ==== logic/asc_timer_end.sv ====
`timescale 1ns/1ps
`default_nettype none
module asc_timer_end import asc_pkg::*; #(
	parameter logic [CW-1:0] PEAK = 16'h00FF,
	parameter logic [7:0] PRESCALE = 8'h04
) (
	input wire logic clk,
	input wire logic arst_n,
	asc_link_if.tmr lnk,
	input wire logic [NTMR-1:0] tmr_run,
	input wire logic [MW-1:0] mask_reload,
	input wire logic [1:0][CW-1:0] output_compare_value_val,
	output logic [NTRIG-1:0] adc_start
);
	logic [7:0] div_r, div_nxt;
	logic [NTMR-1:0][CW-1:0] cnt_r, cnt_nxt;
	logic [NTMR-1:0] up_r, up_nxt;
	logic [NTMR-1:0] run_r, run_nxt;
	logic [NTMR-1:0][MW-1:0] mz_r, mz_nxt, mp_r, mp_nxt;
	logic [NTRIG-1:0] start_r;
	logic tick_en;

	// One shared prescaler; every timer steps on its one-cycle enable.
	assign tick_en = (div_r == BYTE_RST);

	always_comb begin
		div_nxt = tick_en ? PRESCALE - 8'h01 : div_r - 8'h01;
		cnt_nxt = cnt_r;
		up_nxt = up_r;
		mz_nxt = mz_r;
		mp_nxt = mp_r;
		// The run state lags the request by one edge, so the stop flag and the cleared count appear together.
		run_nxt = tmr_run;
		for (int t = 0; t < NTMR; t++) begin
			if (!tmr_run[t]) begin
				cnt_nxt[t] = CMP_RST;
				up_nxt[t] = 1'b1;
			end else if (tick_en && run_r[t]) begin
				if (cnt_r[t] == CMP_RST) begin
					mz_nxt[t] = (mz_r[t] == MASK_ZERO) ? mask_reload : mz_r[t] - 4'h1;
				end
				if (cnt_r[t] == PEAK) begin
					mp_nxt[t] = (mp_r[t] == MASK_ZERO) ? mask_reload : mp_r[t] - 4'h1;
				end
				if (up_r[t] && cnt_r[t] == PEAK) begin
					up_nxt[t] = 1'b0;
					cnt_nxt[t] = cnt_r[t] - CNT_ONE;
				end else if (!up_r[t] && cnt_r[t] == CMP_RST) begin
					up_nxt[t] = 1'b1;
					cnt_nxt[t] = cnt_r[t] + CNT_ONE;
				end else begin
					cnt_nxt[t] = up_r[t] ? cnt_r[t] + CNT_ONE : cnt_r[t] - CNT_ONE;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			div_r <= BYTE_RST;
			cnt_r <= '0;
			up_r <= '1;
			run_r <= '0;
			mz_r <= '0;
			mp_r <= '0;
			start_r <= '0;
		end else begin
			div_r <= div_nxt;
			cnt_r <= cnt_nxt;
			up_r <= up_nxt;
			run_r <= run_nxt;
			mz_r <= mz_nxt;
			mp_r <= mp_nxt;
			start_r <= lnk.adc_trig;
		end
	end

	always_comb begin
		for (int t = 0; t < NTMR; t++) begin
			lnk.frt_count[t] = cnt_r[t];
			lnk.frt_tick[t] = tick_en & run_r[t];
			lnk.frt_zero[t] = run_r[t] & (cnt_r[t] == CMP_RST);
			lnk.frt_peak[t] = run_r[t] & (cnt_r[t] == PEAK);
			lnk.frt_up[t] = up_r[t];
			lnk.frt_stop[t] = ~run_r[t];
			lnk.zero_side_mask_count[t] = mz_r[t];
			lnk.peak_side_mask_count[t] = mp_r[t];
		end
		// Output-compare hits come from timer c / 2, the timer numbered like the channel's pair.
		for (int c = 0; c < NCH; c++) begin
			for (int k = 0; k < 2; k++) begin
				lnk.output_compare_value_match[c][k] = tick_en & run_r[c / 2] & (cnt_r[c / 2] == output_compare_value_val[k]);
			end
		end
	end

	assign adc_start = start_r;
endmodule // asc_timer_end
`default_nettype wire

// ==== logic/asc_compare_dev.sv ====
// Overview of operation
// - Even-channel codes 0,1,2 pick timers 0,1,2.
// - Codes 3 to 8 external; others forbidden.
// - Odd-channel nibble uses identical timer codes.
// - Three pair selectors in bytes of one word.
// - Software changes timer select only while disabled.
// - Pair 1/0 legacy enable: 00 off, 01 on.
// - Pair 3/2 legacy enable at bits 3:2.
// - Pair 5/4 legacy enable at bits 5:4.
// - Legacy mode fields store and read back.
// - Legacy reserved bits read zero, written zero.
// - Unlinked buffer codes: now, zero, peak, either.
// - Linked codes also need mask count zero.
// - Link bit reads zero without link feature.
// - Software changes buffer settings only while disabled.
// - Enabling write still transfers its mask value.
// - Trigger field picks one of eight outputs.
// - Channels may share one trigger output.
// - Channel control bits 7:6 reserved, zero.
// - Six independent per-channel control registers.
// - Any state enable starts the channel.
// - Normal match fires; offset counts down first.
// - Compare writes go through a buffer register.
`timescale 1ns/1ps
`default_nettype none
module asc_compare_dev import asc_pkg::*; #(
	parameter bit HAS_LINK = 1'b1
) (
	input wire logic clk,
	input wire logic arst_n,
	asc_link_if.dev lnk,
	input wire logic reg_wr,
	input wire logic [3:0] reg_be,
	input wire logic [4:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	output logic [NCH-1:0] ch_active
);
	logic [NPAIR-1:0][PAIR_SEL_W-1:0] pair_sel_r, pair_sel_nxt;
	logic [5:0] leg_en_r, leg_en_nxt;
	logic [5:0] leg_mode_r, leg_mode_nxt;
	logic [NCH-1:0][7:0] ctl_r, ctl_nxt;
	logic [NCH-1:0][7:0] mode_r, mode_nxt;
	logic [NCH-1:0][7:0] mcv_buf_r, mcv_buf_nxt, mcv_r, mcv_nxt;
	logic [NCH-1:0][CW-1:0] cmp_buf_r, cmp_buf_nxt, cmp_r, cmp_nxt;
	logic [NCH-1:0][CW-1:0] ofs_r, ofs_nxt;
	logic [NCH-1:0] run_r, run_nxt;
	logic [NTRIG-1:0] trig_r, trig_nxt;
	logic [NCH-1:0] act_r, act_nxt;
	logic [31:0] rd_r, rd_nxt;
	logic [7:0] ctl_wmask;

	// A part without the linked transfer never stores the link bit.
	assign ctl_wmask = HAS_LINK ? (CTL_WMASK | CTL_LINK_MASK) : CTL_WMASK;

	function automatic logic [3:0] chan_code(input logic [NPAIR-1:0][PAIR_SEL_W-1:0] ps, input int ch);
		chan_code = ch[0] ? ps[ch / 2][SEL_ODD_LSB +: 4] : ps[ch / 2][SEL_EVEN_LSB +: 4];
	endfunction

	function automatic logic buf_xfer(input logic [1:0] buffer_transfer_mode, input logic link, input logic zero,
		input logic peak, input logic [MW-1:0] mz, input logic [MW-1:0] mp);
		logic zs;
		logic ps;
		zs = zero & (~link | (mz == MASK_ZERO));
		ps = peak & (~link | (mp == MASK_ZERO));
		unique case (asc_buffer_transfer_mode_t'(buffer_transfer_mode))
			ASC_BUF_NOW: buf_xfer = 1'b0;
			ASC_BUF_ZERO: buf_xfer = zs;
			ASC_BUF_PEAK: buf_xfer = ps;
			ASC_BUF_BOTH: buf_xfer = zs | ps;
		endcase
	endfunction

	function automatic logic in_span(input logic [4:0] a, input logic [4:0] base);
		in_span = (a >= base) && (a < base + ADDR_SPAN);
	endfunction

	always_comb begin
		logic [3:0] code;
		logic [1:0] t;
		logic tv;
		logic zero, peak, up, tick, stop, legacy_on, en_mode, state_ok, fire, hit;
		logic [CW-1:0] cnt;
		logic [MW-1:0] mz, mp;
		logic [2:0] idx;
		logic [1:0] buffer_transfer_mode;
		code = '0;
		t = '0;
		tv = 1'b0;
		zero = 1'b0;
		peak = 1'b0;
		up = 1'b0;
		tick = 1'b0;
		stop = 1'b0;
		legacy_on = 1'b0;
		en_mode = 1'b0;
		state_ok = 1'b0;
		fire = 1'b0;
		hit = 1'b0;
		cnt = '0;
		mz = '0;
		mp = '0;
		idx = 3'(reg_addr - ADDR_CTL_BASE);
		buffer_transfer_mode = '0;
		pair_sel_nxt = pair_sel_r;
		leg_en_nxt = leg_en_r;
		leg_mode_nxt = leg_mode_r;
		ctl_nxt = ctl_r;
		mode_nxt = mode_r;
		mcv_buf_nxt = mcv_buf_r;
		mcv_nxt = mcv_r;
		cmp_buf_nxt = cmp_buf_r;
		cmp_nxt = cmp_r;
		ofs_nxt = ofs_r;
		run_nxt = run_r;
		trig_nxt = '0;
		act_nxt = '0;
		if (reg_wr && reg_addr == ADDR_PAIR_SEL) begin
			for (int p = 0; p < NPAIR; p++) begin
				if (reg_be[p]) begin
					pair_sel_nxt[p] = reg_wdata[p * PAIR_SEL_W +: PAIR_SEL_W];
				end
			end
		end
		if (reg_wr && reg_addr == ADDR_LEGACY) begin
			if (reg_be[0]) begin
				leg_en_nxt = reg_wdata[5:0] & LEG_WMASK;
			end
			if (reg_be[1]) begin
				leg_mode_nxt = reg_wdata[LEG_MODE_LSB +: 6] & LEG_WMASK;
			end
		end
		for (int ch = 0; ch < NCH; ch++) begin
			code = chan_code(pair_sel_r, ch);
			// Codes above two name timers of other units; a single unit leaves the channel idle.
			tv = (code <= TSEL_MAX);
			t = code[1:0];
			cnt = tv ? lnk.frt_count[t] : CMP_RST;
			tick = tv & lnk.frt_tick[t];
			zero = tv & lnk.frt_zero[t];
			peak = tv & lnk.frt_peak[t];
			up = tv & lnk.frt_up[t];
			stop = ~tv | lnk.frt_stop[t];
			mz = tv ? lnk.zero_side_mask_count[t] : MASK_ZERO;
			mp = tv ? lnk.peak_side_mask_count[t] : MASK_ZERO;
			legacy_on = (leg_en_r[(ch / 2) * 2 +: 2] == LEG_ON);
			en_mode = |mode_r[ch][MODE_ZE:MODE_DE];
			act_nxt[ch] = tv & (en_mode | legacy_on);
			state_ok = legacy_on | (zero & mode_r[ch][MODE_ZE]) | (peak & mode_r[ch][MODE_PE])
				| (~zero & ~peak & up & mode_r[ch][MODE_UE]) | (~zero & ~peak & ~up & mode_r[ch][MODE_DE]);
			hit = lnk.output_compare_value_match[ch][mode_r[ch][MODE_OCUS]];
			fire = 1'b0;
			if (act_nxt[ch] && !mode_r[ch][MODE_AMOD]) begin
				fire = tick & state_ok & (cnt == cmp_r[ch]);
				run_nxt[ch] = 1'b0;
			end else if (act_nxt[ch] && hit && state_ok) begin
				ofs_nxt[ch] = cmp_r[ch];
				run_nxt[ch] = (cmp_r[ch] != CMP_RST);
				fire = (cmp_r[ch] == CMP_RST);
			end else if (act_nxt[ch] && run_r[ch] && tick) begin
				ofs_nxt[ch] = ofs_r[ch] - CNT_ONE;
				run_nxt[ch] = (ofs_r[ch] != CNT_ONE);
				fire = (ofs_r[ch] == CNT_ONE);
			end else if (!act_nxt[ch]) begin
				run_nxt[ch] = 1'b0;
			end
			if (fire) begin
				trig_nxt[ctl_r[ch][TRIG_LSB +: 3]] = 1'b1;
			end
			buffer_transfer_mode = ctl_r[ch][BUFFER_TRANSFER_MODE_LSB +: 2];
			// The old buffer code decides a same-cycle write, so enabling does not swallow it.
			if (stop || buf_xfer(buffer_transfer_mode, ctl_r[ch][LINK_BIT], zero, peak, mz, mp)) begin
				cmp_nxt[ch] = cmp_buf_r[ch];
				mcv_nxt[ch] = mcv_buf_r[ch];
			end
			if (reg_wr && in_span(reg_addr, ADDR_CTL_BASE) && idx == 3'(ch)) begin
				if (reg_be[0]) begin
					ctl_nxt[ch] = reg_wdata[7:0] & ctl_wmask;
				end
				if (reg_be[1]) begin
					mcv_buf_nxt[ch] = reg_wdata[MCV_LSB +: 8];
					if (asc_buffer_transfer_mode_t'(buffer_transfer_mode) == ASC_BUF_NOW) begin
						mcv_nxt[ch] = reg_wdata[MCV_LSB +: 8];
					end
				end
			end
			if (reg_wr && reg_be[1] && in_span(reg_addr, ADDR_MODE_BASE) && 3'(reg_addr - ADDR_MODE_BASE) == 3'(ch)) begin
				mode_nxt[ch] = reg_wdata[MODE_LSB +: 8] & MODE_WMASK;
			end
			// Half-word writes only; a lone byte would tear the compare value.
			if (reg_wr && reg_be[1:0] == 2'b11 && in_span(reg_addr, ADDR_CMP_BASE)
				&& 3'(reg_addr - ADDR_CMP_BASE) == 3'(ch)) begin
				cmp_buf_nxt[ch] = reg_wdata[CW-1:0];
				if (asc_buffer_transfer_mode_t'(buffer_transfer_mode) == ASC_BUF_NOW) begin
					cmp_nxt[ch] = reg_wdata[CW-1:0];
				end
			end
		end
	end

	always_comb begin
		rd_nxt = WORD_ZERO;
		if (reg_addr == ADDR_PAIR_SEL) begin
			rd_nxt[NPAIR * PAIR_SEL_W - 1:0] = pair_sel_r;
		end else if (reg_addr == ADDR_LEGACY) begin
			rd_nxt[5:0] = leg_en_r;
			rd_nxt[LEG_MODE_LSB +: 6] = leg_mode_r;
		end else if (in_span(reg_addr, ADDR_CTL_BASE)) begin
			rd_nxt[7:0] = ctl_r[3'(reg_addr - ADDR_CTL_BASE)];
			rd_nxt[MCV_LSB +: 8] = mcv_r[3'(reg_addr - ADDR_CTL_BASE)];
		end else if (in_span(reg_addr, ADDR_MODE_BASE)) begin
			rd_nxt[MODE_LSB +: 8] = mode_r[3'(reg_addr - ADDR_MODE_BASE)];
		end else if (in_span(reg_addr, ADDR_CMP_BASE)) begin
			rd_nxt[CW-1:0] = cmp_r[3'(reg_addr - ADDR_CMP_BASE)];
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pair_sel_r <= '0;
			leg_en_r <= '0;
			leg_mode_r <= '0;
			ctl_r <= '0;
			mode_r <= '0;
			mcv_buf_r <= '0;
			mcv_r <= '0;
			cmp_buf_r <= '0;
			cmp_r <= '0;
			ofs_r <= '0;
			run_r <= '0;
			trig_r <= '0;
			act_r <= '0;
			rd_r <= WORD_ZERO;
		end else begin
			pair_sel_r <= pair_sel_nxt;
			leg_en_r <= leg_en_nxt;
			leg_mode_r <= leg_mode_nxt;
			ctl_r <= ctl_nxt;
			mode_r <= mode_nxt;
			mcv_buf_r <= mcv_buf_nxt;
			mcv_r <= mcv_nxt;
			cmp_buf_r <= cmp_buf_nxt;
			cmp_r <= cmp_nxt;
			ofs_r <= ofs_nxt;
			run_r <= run_nxt;
			trig_r <= trig_nxt;
			act_r <= act_nxt;
			rd_r <= rd_nxt;
		end
	end

	assign lnk.adc_trig = trig_r;
	assign reg_rdata = rd_r;
	assign ch_active = act_r;
endmodule // asc_compare_dev
`default_nettype wire

// ==== tb/asc_compare_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module asc_compare_asserts import asc_pkg::*; #(
	parameter logic [CW-1:0] PEAK = 16'h00FF
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [NTMR-1:0][CW-1:0] frt_count,
	input wire logic [NTMR-1:0] frt_tick,
	input wire logic [NTMR-1:0] frt_zero,
	input wire logic [NTMR-1:0] frt_peak,
	input wire logic [NTMR-1:0] frt_stop,
	input wire logic [NCH-1:0][1:0] output_compare_value_match,
	input wire logic [NTRIG-1:0] adc_trig
);
	logic [NTMR-1:0] at_zero;
	logic [NTMR-1:0] at_peak;
	always_comb begin
		for (int t = 0; t < NTMR; t++) begin
			at_zero[t] = frt_count[t] == CMP_RST;
			at_peak[t] = frt_count[t] == PEAK;
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	sequence s_fire;
		adc_trig != '0;
	endsequence
	sequence s_stepped;
		$past(frt_tick) != '0;
	endsequence
	a_trig_has_step: assert property (s_fire |-> s_stepped) else $error("trigger without step");
	a_trig_one_cycle: assert property ((adc_trig & $past(adc_trig)) == '0) else $error("trigger too wide");
	a_tick_one_cycle: assert property ((frt_tick & $past(frt_tick)) == '0) else $error("step too wide");
	a_match_one_cycle: assert property ((output_compare_value_match & $past(output_compare_value_match)) == '0) else $error("match too wide");
	a_stop_count_zero: assert property ((frt_stop & ~at_zero) == '0) else $error("stopped count not zero");
	a_zero_flag_exact: assert property (frt_zero == (~frt_stop & at_zero)) else $error("zero status wrong");
	a_peak_flag_exact: assert property (frt_peak == (~frt_stop & at_peak)) else $error("peak status wrong");
	a_reset_quiet: assert property (@(posedge clk) disable iff (1'b0) !arst_n |-> adc_trig == '0)
		else $error("trigger in reset");
endmodule // asc_compare_asserts
`default_nettype wire

// ==== tb/adc_start_compare_config_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module adc_start_compare_config_tb import asc_pkg::*; ();
	localparam logic [CW-1:0] TB_PEAK = 16'h00FF;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic reg_wr = 1'b0;
	logic [3:0] reg_be = 4'h0;
	logic [4:0] reg_addr = 5'h00;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic [31:0] reg_rdata;
	logic [NCH-1:0] ch_active;
	logic [NTMR-1:0] tmr_run = 3'h0;
	logic [MW-1:0] mask_reload = 4'h0;
	logic [1:0][CW-1:0] output_compare_value_val = 32'h0000_0000;
	logic [NTRIG-1:0] adc_start;
	int n_errors = 0;
	int total_checks = 0;
	int seed = 26193;
	logic [31:0] mdl [0:31];
	int exp_hits [NTRIG];
	int got_hits [NTRIG];
	int ofs [NCH];
	asc_link_if lnk ();
	asc_compare_dev #(.HAS_LINK(1'b1)) asc_compare_dev_i (.clk(clk), .arst_n(arst_n), .lnk(lnk), .reg_wr(reg_wr),
		.reg_be(reg_be), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ch_active(ch_active));
	asc_timer_end #(.PEAK(TB_PEAK), .PRESCALE(8'h04)) asc_timer_end_i (.clk(clk), .arst_n(arst_n), .lnk(lnk),
		.tmr_run(tmr_run), .mask_reload(mask_reload), .output_compare_value_val(output_compare_value_val), .adc_start(adc_start));
	asc_compare_asserts #(.PEAK(TB_PEAK)) asc_compare_asserts_i (.clk(clk), .arst_n(arst_n), .frt_count(lnk.frt_count),
		.frt_tick(lnk.frt_tick), .frt_zero(lnk.frt_zero), .frt_peak(lnk.frt_peak), .frt_stop(lnk.frt_stop),
		.output_compare_value_match(lnk.output_compare_value_match), .adc_trig(lnk.adc_trig));
	initial begin
		forever #20 clk = ~clk;
	end
	function automatic logic [31:0] wmask(input int a);
		if (a == 0) return 32'h00FF_FFFF;
		if (a == 1) return 32'h0000_3F3F;
		if (a < 8) return 32'h0000_FF3F;
		if (a < 14) return 32'h0000_F300;
		if (a < 20) return 32'h0000_FFFF;
		return 32'h0000_0000;
	endfunction
	function automatic logic [3:0] tsel(input int c);
		return mdl[0][(c / 2) * 8 + (c % 2) * 4 +: 4];
	endfunction
	function automatic logic [NCH-1:0] exp_active();
		logic [NCH-1:0] r;
		for (int c = 0; c < NCH; c++) begin
			r[c] = ((|mdl[8 + c][15:12]) || mdl[1][(c / 2) * 2 +: 2] == LEG_ON) && tsel(c) <= TSEL_MAX;
		end
		return r;
	endfunction
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [3:0] be, input logic [31:0] d);
		logic [31:0] m;
		m = wmask(a);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_be <= be;
		reg_wdata <= d;
		for (int b = 0; b < 4; b++) begin
			if (be[b] && (a < 14 || a > 19 || be[1:0] == 2'b11)) mdl[a][b * 8 +: 8] = d[b * 8 +: 8] & m[b * 8 +: 8];
		end
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] exp);
		@(posedge clk);
		reg_addr <= a;
		repeat (2) @(posedge clk);
		#1;
		chk($sformatf("register %0d", a), exp, reg_rdata);
	endtask
	task automatic wait_for(input int which);
		for (int i = 0; i < 6000; i++) begin
			@(posedge clk);
			#1;
			if (which == 0 && lnk.frt_count[0] === 16'h0040) return;
			if (which == 1 && lnk.frt_zero[0] === 1'b1) return;
			if (which == 2 && lnk.frt_peak[0] === 1'b1) return;
		end
		chk("timer state wait", 32'h0000_0001, 32'h0000_0000);
		final_report();
	endtask
	always @(negedge clk) begin : trig_model
		logic [NCH-1:0] act;
		logic [NTRIG-1:0] ev;
		logic [3:0] t;
		act = exp_active();
		ev = '0;
		for (int c = 0; c < NCH; c++) begin
			t = tsel(c);
			if (act[c] && !mdl[8 + c][8] && lnk.frt_tick[t] === 1'b1 && lnk.frt_count[t] === mdl[14 + c][15:0])
				ev[mdl[2 + c][4:2]] = 1'b1;
			if (!act[c] || !mdl[8 + c][8]) begin
				ofs[c] = 0;
			end else if (lnk.output_compare_value_match[c][mdl[8 + c][9]] === 1'b1) begin
				ofs[c] = int'(mdl[14 + c][15:0]);
				if (ofs[c] == 0) ev[mdl[2 + c][4:2]] = 1'b1;
			end else if (ofs[c] > 0 && lnk.frt_tick[t] === 1'b1) begin
				ofs[c]--;
				if (ofs[c] == 0) ev[mdl[2 + c][4:2]] = 1'b1;
			end
		end
		for (int d = 0; d < NTRIG; d++) begin
			exp_hits[d] += ev[d];
			got_hits[d] += (adc_start[d] === 1'b1);
		end
	end
	task automatic final_report();
		if (n_errors == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		repeat (80000) @(posedge clk);
		n_errors++;
		final_report();
	end
	initial begin : main
		logic [31:0] v;
		logic [15:0] cur;
		int c;
		int c2;
		for (int a = 0; a < 32; a++) mdl[a] = 32'h0000_0000;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		output_compare_value_val <= {$random(seed)} & 32'h00FF_00FF;
		for (int a = 0; a < 32; a++) rd(5'(a), 32'h0000_0000);
		for (int i = 0; i < 60; i++) begin
			v = $random(seed);
			c = {$random(seed)} % 24;
			wr(5'(c), v[3:0] | 4'h1, $random(seed));
			rd(5'(c), mdl[c]);
			chk("ch_active", 32'(exp_active()), 32'(ch_active));
		end
		for (int a = 0; a < 20; a++) wr(5'(a), 4'hF, 32'h0000_0000);
		for (int d = 0; d < NTRIG; d++) begin
			c = d % NCH;
			c2 = (d + 1) % NCH;
			v = mdl[0];
			v[(c / 2) * 8 + (c % 2) * 4 +: 4] = 4'(d % NTMR);
			v[(c2 / 2) * 8 + (c2 % 2) * 4 +: 4] = 4'((d + 1) % NTMR);
			wr(5'h00, 4'h7, v);
			for (int k = 0; k < 2; k++) begin
				v = $random(seed);
				wr(5'(14 + (k ? c2 : c)), 4'h3, {25'h0, v[6:1], 1'b1});
				wr(5'(2 + (k ? c2 : c)), 4'h1, {27'h0, 3'(d), 2'b00});
				wr(5'(8 + (k ? c2 : c)), 4'h2, {16'h0, 4'hF, 2'b00, v[7], d > 3, 8'h00});
			end
			repeat (2) @(posedge clk);
			chk("ch_active", 32'(exp_active()), 32'(ch_active));
			for (int e = 0; e < NTRIG; e++) exp_hits[e] = 0;
			for (int e = 0; e < NTRIG; e++) got_hits[e] = 0;
			tmr_run <= 3'h7;
			repeat (4200) @(posedge clk);
			tmr_run <= 3'h0;
			repeat (10) @(posedge clk);
			for (int e = 0; e < NTRIG; e++) chk("trigger count", 32'(exp_hits[e]), 32'(got_hits[e]));
			wr(5'(8 + c), 4'h2, 32'h0000_0000);
			wr(5'(8 + c2), 4'h2, 32'h0000_0000);
		end
		wr(5'h00, 4'h7, 32'h0000_0000);
		cur = 16'h0011;
		wr(5'h0E, 4'h3, 32'(cur));
		rd(5'h0E, 32'(cur));
		for (int k = 1; k < 4; k++) begin
			// Enabling the buffer must go from the unbuffered code to test the combined word write.
			wr(5'h02, 4'h1, 32'h0000_0000);
			v = $random(seed);
			wr(5'h02, 4'h3, {16'h0, v[15:8], 2'b00, k == 3, 3'b000, 2'(k)});
			rd(5'h02, {16'h0, v[15:8], 2'b00, k == 3, 3'b000, 2'(k)});
			tmr_run <= 3'h1;
			wait_for(0);
			wr(5'h0E, 4'h3, {16'h0, v[15:0]});
			rd(5'h0E, 32'(cur));
			wait_for(k == 1 ? 1 : 2);
			cur = v[15:0];
			rd(5'h0E, 32'(cur));
			tmr_run <= 3'h0;
			repeat (3) @(posedge clk);
		end
		final_report();
	end
endmodule // adc_start_compare_config_tb
`default_nettype wire
